// file: core/sdq_pkg.sv
package sdq_pkg;
    // command opcodes
    localparam logic [7:0] OPC_COUNT   = 8'h11;
    localparam logic [7:0] OPC_STATUS  = 8'h14;
    localparam logic [7:0] OPC_TONE    = 8'h0D;
    localparam logic [7:0] OPC_TIME    = 8'h0E;
    localparam logic [7:0] OPC_ERRW    = 8'h1B;
    localparam logic [7:0] OPC_STOP    = 8'h08;
    localparam logic [7:0] OPC_INIT    = 8'h01;
    // byte counts per command
    localparam logic [2:0] CNT_COUNT   = 3'h4;
    localparam logic [2:0] CNT_ONE     = 3'h1;
    localparam logic [2:0] CNT_REPLY   = 3'h2;
    // event status word layout
    localparam int         ST_DIG_LSB  = 0;
    localparam int         ST_DIG_MSB  = 3;
    localparam int         ST_DEND_B   = 4;
    localparam int         ST_OPOK_B   = 5;
    localparam int         ST_FULL_B   = 6;
    localparam int         ST_ERR_B    = 7;
    localparam int         ST_BUSY_B   = 8;
    localparam int         ST_DIAL_B   = 9;
    localparam int         ST_LOW_B    = 10;
    localparam int         ST_NRG_B    = 12;
    localparam int         ST_SIL_B    = 13;
    localparam int         ST_PWR_B    = 14;
    localparam int         ST_DSTART_B = 15;
    localparam logic [15:0] ST_RESET   = 16'h0000;
    // error word bits
    localparam int         ERR_OPC_B   = 1;
    localparam int         ERR_INV_B   = 7;
    localparam logic [15:0] ERR_RESET  = 16'h0000;
    // time word
    localparam logic [1:0] TD_SET      = 2'h3;
    localparam logic [1:0] TD_UNSET    = 2'h0;
    localparam logic [7:0] TD_OPT_SYS  = 8'h00;
    localparam logic [7:0] TD_OPT_MSG  = 8'h01;
    // tone byte
    localparam int         TONE_STEP_HZ = 100;
    typedef enum logic [1:0] {
        SDQ_IDLE  = 2'b00,
        SDQ_PARAM = 2'b01,
        SDQ_REPLY = 2'b10
    } sdq_st_t;
endpackage : sdq_pkg

// file: core/sdq_link_if.sv
`timescale 1ns/1ns
interface sdq_link_if;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic [7:0] tx_byte;
    logic       tx_echo;
    modport link (output rx_byte, output rx_tgl, input tx_byte, input tx_echo);
    modport core (input rx_byte, input rx_tgl, output tx_byte, output tx_echo);
endinterface : sdq_link_if

// file: core/sdq_sync.sv
`timescale 1ns/1ns
module sdq_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sdq_sync_t;
    sdq_sync_t r_q, r_d;
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign q = r_q.s2;
endmodule : sdq_sync

// file: core/sdq_link.sv
`timescale 1ns/1ns
module sdq_link (
    // link clock and device reset
    input  wire logic sk_clk,
    input  wire logic sys_rst,
    // serial pins
    input  wire logic sdi,
    output logic      sdo,
    // towards core
    sdq_link_if.link  lk
);
    typedef struct packed {
        logic [2:0] bits;
        logic [7:0] shi;
        logic [7:0] sho;
        logic       sdo;
        logic [7:0] rxb;
        logic       tgl;
    } sdq_link_t;
    sdq_link_t q, d;
    logic      lrst;
    sdq_sync #(.W(1)) u_rst (.clk(sk_clk), .rst(1'b0), .d(sys_rst), .q(lrst));
    always_comb begin
        d = q;
        d.bits = q.bits + 3'h1;
        d.shi = {q.shi[6:0], sdi};
        d.sho = (q.bits == 3'h0) ? {lk.tx_byte[6:0], 1'b0} : {q.sho[6:0], 1'b0};
        // echo passes the host bit back one edge late
        if (lk.tx_echo) begin
            d.sdo = sdi;
        end else begin
            d.sdo = (q.bits == 3'h0) ? lk.tx_byte[7] : q.sho[7];
        end
        if (q.bits == 3'h7) begin
            d.rxb = {q.shi[6:0], sdi};
            d.tgl = ~q.tgl;
        end
    end
    always_ff @(posedge sk_clk) begin
        if (lrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign sdo = q.sdo;
    assign lk.rx_byte = q.rxb;
    assign lk.rx_tgl = q.tgl;
endmodule : sdq_link

// file: core/sdq_core.sv
`timescale 1ns/1ns
module sdq_core import sdq_pkg::*; #(
    parameter int MSGS = 16
) (
    // device clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // serial link
    input  wire logic                    sk_clk,
    input  wire logic                    sdi,
    output logic                         sdo,
    output logic                         host_service_request_n,
    // detector events, one-cycle pulses
    input  wire logic                    dtmf_start_flag_start,
    input  wire logic                    dtmf_done_flag,
    input  wire logic [3:0]              ev_digit,
    input  wire logic                    ev_op_done,
    input  wire logic                    ev_full,
    input  wire logic                    busy_tone_flag,
    input  wire logic                    ev_dial,
    input  wire logic                    ev_low,
    input  wire logic                    ev_nrg,
    input  wire logic                    ev_silence,
    // message directory
    input  wire logic                    tag_we,
    input  wire logic [$clog2(MSGS)-1:0] tag_idx,
    input  wire logic [15:0]             tag_data,
    input  wire logic                    tag_live,
    input  wire logic                    cur_msg_ok,
    input  wire logic [15:0]             cur_stamp,
    // real-time clock
    input  wire logic [13:0]             sys_td,
    input  wire logic                    time_set,
    // tone generator control
    output logic                         tone_on,
    output logic                         tone_dtmf,
    output logic [1:0]                   tone_row,
    output logic [1:0]                   tone_col,
    output logic [11:0]                  tone_hz
);
    typedef struct packed {
        sdq_st_t     st;
        logic [7:0]  opc;
        logic [2:0]  cnt;
        logic [31:0] par;
        logic [15:0] reply;
        logic [15:0] stat;
        logic [15:0] errw;
        logic        req_low;
        logic        pwr_pend;
        logic        rx_seen;
        logic [7:0]  tx_byte;
        logic        tx_echo;
        logic        tone_on;
        logic        tone_dtmf;
        logic [1:0]  tone_row;
        logic [1:0]  tone_col;
        logic [11:0] tone_hz;
    } sdq_core_t;

    localparam sdq_core_t Q_RST = '{
        st: SDQ_IDLE,
        stat: ST_RESET,
        errw: ERR_RESET,
        pwr_pend: 1'b1,
        tx_echo: 1'b1,
        default: '0
    };

    sdq_core_t        q, d;
    sdq_link_if       lk ();
    logic             rx_tgl_s;
    logic             byte_ev;
    logic [7:0]       rxb;
    logic [15:0]      tag_mem [MSGS];
    logic [MSGS-1:0]  live_q;
    logic [15:0]      ev;
    logic [15:0]      base;
    logic             err_opc;
    logic             err_inv;
    logic             rd_stat;
    logic             do_init;
    logic             st_done;
    logic             ew_done;
    logic [15:0]      match_cnt;

    // link side and crossing of the byte toggle
    sdq_link u_link (.sk_clk(sk_clk), .sys_rst(sys_rst), .sdi(sdi), .sdo(sdo), .lk(lk));
    sdq_sync #(.W(1)) u_rx (.clk(ref_clk), .rst(sys_rst), .d(lk.rx_tgl), .q(rx_tgl_s));
    assign byte_ev = rx_tgl_s ^ q.rx_seen;
    assign rxb = lk.rx_byte;

    // message tag directory
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            live_q <= '0;
        end else if (tag_we) begin
            live_q[tag_idx] <= tag_live;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (tag_we) begin
            tag_mem[tag_idx] <= tag_data;
        end
    end

    function automatic logic [15:0] count_tags(input logic [15:0] tref,
                                               input logic [15:0] tmask);
        logic [15:0] n;
        n = 16'h0000;
        for (int i = 0; i < MSGS; i++) begin
            // masked compare, zero mask matches all live entries
            if (live_q[i] && ((tag_mem[i] & tmask) == (tref & tmask))) begin
                n = n + 16'h0001;
            end
        end
        return n;
    endfunction : count_tags

    // keypad position {row, col} of a dtmf code
    function automatic logic [3:0] dtmf_key(input logic [3:0] code);
        logic [3:0] k;
        case (code)
            4'h0: k = 4'hD;
            4'h1: k = 4'h0;
            4'h2: k = 4'h1;
            4'h3: k = 4'h2;
            4'h4: k = 4'h4;
            4'h5: k = 4'h5;
            4'h6: k = 4'h6;
            4'h7: k = 4'h8;
            4'h8: k = 4'h9;
            4'h9: k = 4'hA;
            4'hA: k = 4'h3;
            4'hB: k = 4'hC;
            4'hC: k = 4'hE;
            4'hD: k = 4'h7;
            4'hE: k = 4'hB;
            default: k = 4'hF;
        endcase
        return k;
    endfunction : dtmf_key

    // reference sits two bytes above the mask, last mask byte is on the link
    always_comb begin
        match_cnt = count_tags(q.par[23:8], {q.par[7:0], rxb});
    end

    always_comb begin
        d = q;
        err_opc = 1'b0;
        err_inv = 1'b0;
        rd_stat = 1'b0;
        do_init = 1'b0;
        st_done = 1'b0;
        ew_done = 1'b0;
        if (byte_ev) begin
            d.rx_seen = ~q.rx_seen;
            d.tx_echo = 1'b1;
            case (q.st)
                SDQ_IDLE: begin
                    d.opc = rxb;
                    case (rxb)
                        OPC_COUNT: begin
                            d.st = SDQ_PARAM;
                            d.cnt = CNT_COUNT;
                        end
                        OPC_TONE, OPC_TIME: begin
                            d.st = SDQ_PARAM;
                            d.cnt = CNT_ONE;
                        end
                        OPC_STATUS: begin
                            rd_stat = 1'b1;
                            d.reply = q.stat;
                            d.st = SDQ_REPLY;
                            d.cnt = CNT_REPLY;
                            d.tx_echo = 1'b0;
                            d.tx_byte = q.stat[15:8];
                        end
                        OPC_ERRW: begin
                            d.reply = q.errw;
                            d.st = SDQ_REPLY;
                            d.cnt = CNT_REPLY;
                            d.tx_echo = 1'b0;
                            d.tx_byte = q.errw[15:8];
                        end
                        OPC_STOP: begin
                            d.tone_on = 1'b0;
                        end
                        OPC_INIT: begin
                            do_init = 1'b1;
                        end
                        default: begin
                            // unknown opcode is not run
                            err_opc = 1'b1;
                            d.errw[ERR_OPC_B] = 1'b1;
                        end
                    endcase
                end
                SDQ_PARAM: begin
                    d.par = {q.par[23:0], rxb};
                    d.cnt = q.cnt - 3'h1;
                    if (q.cnt == CNT_ONE) begin
                        d.st = SDQ_IDLE;
                        case (q.opc)
                            OPC_COUNT: begin
                                d.reply = match_cnt;
                                d.st = SDQ_REPLY;
                                d.cnt = CNT_REPLY;
                                d.tx_echo = 1'b0;
                                d.tx_byte = match_cnt[15:8];
                            end
                            OPC_TONE: begin
                                // byte taken as sent, no range
                                d.tone_on = 1'b1;
                                d.tone_dtmf = rxb[0];
                                {d.tone_row, d.tone_col} = dtmf_key(rxb[4:1]);
                                d.tone_hz = 12'(int'(rxb[5:1]) * TONE_STEP_HZ);
                            end
                            default: begin
                                // time word select
                                if (rxb == TD_OPT_MSG && !cur_msg_ok) begin
                                    err_inv = 1'b1;
                                    d.errw[ERR_INV_B] = 1'b1;
                                    d.reply = 16'h0000;
                                end else if (rxb == TD_OPT_SYS) begin
                                    d.reply = {time_set ? TD_SET : TD_UNSET, sys_td};
                                end else begin
                                    d.reply = cur_stamp;
                                end
                                d.st = SDQ_REPLY;
                                d.cnt = CNT_REPLY;
                                d.tx_echo = 1'b0;
                                d.tx_byte = d.reply[15:8];
                            end
                        endcase
                    end
                end
                SDQ_REPLY: begin
                    // host fills, device shifts the reply out
                    d.cnt = q.cnt - 3'h1;
                    if (q.cnt == CNT_REPLY) begin
                        d.tx_echo = 1'b0;
                        d.tx_byte = q.reply[7:0];
                    end else begin
                        d.st = SDQ_IDLE;
                        st_done = (q.opc == OPC_STATUS);
                        ew_done = (q.opc == OPC_ERRW);
                    end
                end
                default: begin
                    d.st = SDQ_IDLE;
                end
            endcase
        end
        if (ew_done) begin
            d.errw = ERR_RESET;
        end

        // status word update, a new event beats the clear
        ev = 16'h0000;
        ev[ST_DEND_B] = dtmf_done_flag;
        ev[ST_OPOK_B] = ev_op_done;
        ev[ST_FULL_B] = ev_full;
        ev[ST_ERR_B] = err_opc | err_inv;
        ev[ST_BUSY_B] = busy_tone_flag;
        ev[ST_DIAL_B] = ev_dial;
        ev[ST_LOW_B] = ev_low;
        ev[ST_NRG_B] = ev_nrg;
        ev[ST_SIL_B] = ev_silence;
        ev[ST_PWR_B] = q.pwr_pend;
        ev[ST_DSTART_B] = dtmf_start_flag_start;
        base = st_done ? ST_RESET : q.stat;
        if (do_init) begin
            base[ST_PWR_B] = 1'b0;
        end
        d.stat = base | ev;
        if (dtmf_done_flag) begin
            d.stat[ST_DIG_MSB:ST_DIG_LSB] = ev_digit;
        end
        d.pwr_pend = 1'b0;
        // request falls on any newly set flag bit (a new digit field alone does not pull it), rises on status read
        d.req_low = (|(ev & ~base)) | (q.req_low & ~rd_stat);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= Q_RST;
        end else begin
            q <= d;
        end
    end

    assign lk.tx_byte = q.tx_byte;
    assign lk.tx_echo = q.tx_echo;
    assign host_service_request_n = ~q.req_low;
    assign tone_on = q.tone_on;
    assign tone_dtmf = q.tone_dtmf;
    assign tone_row = q.tone_row;
    assign tone_col = q.tone_col;
    assign tone_hz = q.tone_hz;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_REQ_EVENT: assert property (busy_tone_flag |=> !host_service_request_n)
        else $error("busy event did not pull request low");
    AST_REQ_HOLD: assert property (
        !host_service_request_n && !rd_stat |=> !host_service_request_n)
        else $error("request released without status read");
    AST_PWR_UP: assert property (
        $fell(sys_rst) |-> ##[0:2] (!host_service_request_n && q.stat[ST_PWR_B]))
        else $error("power-up flag or request missing");
    AST_STAT_CLR: assert property (st_done && ev == 16'h0000 |=> q.stat == ST_RESET)
        else $error("status not cleared after read");
    AST_STAT_RET: assert property (
        rd_stat |=> q.reply == $past(q.stat) && !q.tx_echo && q.tx_byte == $past(q.stat[15:8]))
        else $error("status reply wrong");
    AST_COUNT: assert property (
        byte_ev && q.st == SDQ_PARAM && q.opc == OPC_COUNT && q.cnt == CNT_ONE
        |=> q.reply == $past(match_cnt) && q.st == SDQ_REPLY)
        else $error("count reply wrong");
    AST_TONE_ON: assert property (
        byte_ev && q.st == SDQ_PARAM && q.opc == OPC_TONE && q.cnt == CNT_ONE |=> q.tone_on)
        else $error("tone not started");
    AST_TONE_KEEP: assert property (
        q.tone_on && !(byte_ev && q.st == SDQ_IDLE && rxb == OPC_STOP) |=> q.tone_on)
        else $error("tone stopped without stop command");
    AST_ERR_OPC: assert property (
        err_opc |=> q.stat[ST_ERR_B] && q.errw[ERR_OPC_B] ##1 !host_service_request_n)
        else $error("bad opcode not flagged");
    AST_TD_INV: assert property (err_inv |=> q.errw[ERR_INV_B] && q.stat[ST_ERR_B])
        else $error("invalid context not flagged");
    AST_TD_SYS: assert property (
        byte_ev && q.st == SDQ_PARAM && q.opc == OPC_TIME && q.cnt == CNT_ONE
        && rxb == TD_OPT_SYS |=> q.reply[15:14] == ($past(time_set) ? TD_SET : TD_UNSET))
        else $error("time set bits wrong");
    AST_EW_CLR: assert property (ew_done |=> q.errw == ERR_RESET)
        else $error("error word not cleared");

    COV_COUNT: cover property (q.st == SDQ_REPLY && q.opc == OPC_COUNT);
    COV_STAT_READ: cover property (st_done);
    COV_TONE: cover property ($rose(q.tone_on));
endmodule : sdq_core

// file: verification/sdq_host.sv
`timescale 1ns/1ns
module sdq_host (
    // link pins
    output logic      sk_clk,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sk_clk = 1'b0;
        sdi    = 1'b0;
    end

    // free clock edges, only around reset
    task automatic kick(input int n);
        repeat (n) begin
            #16 sk_clk = 1'b1;
            #16 sk_clk = 1'b0;
        end
    endtask : kick

    // one byte each way, msb first; clock stands low between bytes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #16 sk_clk = 1'b1;
            #16 sk_clk = 1'b0;
            rx[i] = sdo;
        end
        sdi = ~sdi;
        #400;
    endtask : xfer
endmodule : sdq_host

// file: verification/tb_speech_dsp_query_tone_commands.sv
`timescale 1ns/1ns
module tb_speech_dsp_query_tone_commands import sdq_pkg::*;;
    localparam logic [3:0] KP [16] = '{4'hD, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8,
                                       4'h9, 4'hA, 4'h3, 4'hC, 4'hE, 4'h7, 4'hB, 4'hF};
    logic        ref_clk, sys_rst, sk_clk, sdi, sdo, req_n;
    logic        ds, de, od, fu, bu, di, lo, ng, si;
    logic        tag_we, tag_live, cur_ok, time_set;
    logic        t_on, t_dtmf;
    logic [1:0]  t_row, t_col;
    logic [11:0] t_hz;
    logic [3:0]  dig, tag_idx;
    logic [13:0] sys_td;
    logic [15:0] tag_data, cur_stamp, r;
    int          err_total, samples_checked;

    sdq_host host (.sk_clk(sk_clk), .sdi(sdi), .sdo(sdo));

    sdq_core #(.MSGS(16)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sk_clk(sk_clk), .sdi(sdi), .sdo(sdo),
        .host_service_request_n(req_n), .dtmf_start_flag_start(ds), .dtmf_done_flag(de),
        .ev_digit(dig), .ev_op_done(od), .ev_full(fu), .busy_tone_flag(bu), .ev_dial(di),
        .ev_low(lo), .ev_nrg(ng), .ev_silence(si), .tag_we(tag_we), .tag_idx(tag_idx),
        .tag_data(tag_data), .tag_live(tag_live), .cur_msg_ok(cur_ok),
        .cur_stamp(cur_stamp), .sys_td(sys_td), .time_set(time_set), .tone_on(t_on),
        .tone_dtmf(t_dtmf), .tone_row(t_row), .tone_col(t_col), .tone_hz(t_hz)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checked=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic do_reset();
        @(negedge ref_clk);
        sys_rst = 1'b1;
        fork
            host.kick(4);
            repeat (6) @(negedge ref_clk);
        join
        sys_rst = 1'b0;
        // two link edges flush the link reset; a third would shift a stray bit
        host.kick(2);
    endtask : do_reset

    // opcode, params high byte first, then filler per reply byte
    task automatic cmd(input logic [7:0] op, input logic [31:0] p, input int np,
                       input int nr, output logic [15:0] rep);
        logic [7:0] b;
        host.xfer(op, b);
        chk({8'h00, b}, {8'h00, op});
        for (int i = np - 1; i >= 0; i--) begin
            host.xfer(p[i*8 +: 8], b);
            chk({8'h00, b}, {8'h00, p[i*8 +: 8]});
        end
        rep = '0;
        for (int i = 0; i < nr; i++) begin
            host.xfer(8'hAA, b);
            rep = {rep[7:0], b};
        end
    endtask : cmd

    task automatic wreq(input logic v);
        int n;
        n = 0;
        while (req_n !== v && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0000, req_n}, {15'h0000, v});
    endtask : wreq

    task automatic t_pwr();
        wreq(1'b0);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'h4000);
        wreq(1'b1);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'h0000);
        $display("test pwr done");
    endtask : t_pwr

    task automatic t_events();
        @(negedge ref_clk);
        {ds, de, od, fu, bu, di, lo, ng, si} = 9'h1FF;
        dig = 4'h5;
        @(negedge ref_clk);
        {ds, de, od, fu, bu, di, lo, ng, si} = 9'h000;
        wreq(1'b0);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'hB775);
        $display("test events done");
    endtask : t_events

    task automatic t_count();
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            tag_we = 1'b1;
            tag_idx = i[3:0];
            tag_data = 16'(i);
            tag_live = (i < 10);
        end
        @(negedge ref_clk);
        tag_we = 1'b0;
        cmd(OPC_COUNT, 32'hFFFE0003, 4, 2, r);
        chk(r, 16'h0002);
        cmd(OPC_COUNT, 32'h00010001, 4, 2, r);
        chk(r, 16'h0005);
        cmd(OPC_COUNT, 32'h12340000, 4, 2, r);
        chk(r, 16'h000A);
        $display("test count done");
    endtask : t_count

    task automatic t_err();
        cmd(8'h3F, 32'h0, 0, 0, r);
        wreq(1'b0);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'h0080);
        cmd(OPC_ERRW, 32'h0, 0, 2, r);
        chk(r, 16'h0002);
        cmd(OPC_ERRW, 32'h0, 0, 2, r);
        chk(r, 16'h0000);
        $display("test err done");
    endtask : t_err

    task automatic t_time();
        @(negedge ref_clk);
        sys_td = 14'h1529;
        time_set = 1'b1;
        cur_ok = 1'b1;
        cur_stamp = 16'hE829;
        cmd(OPC_TIME, 32'h0, 1, 2, r);
        chk(r, 16'hD529);
        cmd(OPC_TIME, 32'h1, 1, 2, r);
        chk(r, 16'hE829);
        cmd(OPC_TIME, 32'h5, 1, 2, r);
        chk(r, 16'hE829);
        @(negedge ref_clk);
        time_set = 1'b0;
        cmd(OPC_TIME, 32'h0, 1, 2, r);
        chk(r, 16'h1529);
        @(negedge ref_clk);
        cur_ok = 1'b0;
        cmd(OPC_TIME, 32'h1, 1, 2, r);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'h0080);
        cmd(OPC_ERRW, 32'h0, 0, 2, r);
        chk(r, 16'h0080);
        $display("test time done");
    endtask : t_time

    task automatic t_tone();
        cmd(OPC_TONE, 32'h20, 1, 0, r);
        chk({2'b00, t_on, t_dtmf, t_hz}, {4'h2, 12'h640});
        for (int c = 0; c < 16; c++) begin
            cmd(OPC_TONE, {27'h0, c[3:0], 1'b1}, 1, 0, r);
            chk({10'h000, t_on, t_dtmf, t_row, t_col}, {12'h003, KP[c]});
        end
        cmd(OPC_STOP, 32'h0, 0, 0, r);
        chk({15'h0000, t_on}, 16'h0000);
        $display("test tone done");
    endtask : t_tone

    task automatic t_init();
        do_reset();
        wreq(1'b0);
        cmd(OPC_INIT, 32'h0, 0, 0, r);
        cmd(OPC_STATUS, 32'h0, 0, 2, r);
        chk(r, 16'h0000);
        $display("test init done");
    endtask : t_init

    initial begin
        #3000000;
        err_total++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        {ds, de, od, fu, bu, di, lo, ng, si} = '0;
        {tag_we, tag_live, cur_ok, time_set} = '0;
        dig = '0;
        tag_idx = '0;
        tag_data = '0;
        cur_stamp = '0;
        sys_td = '0;
        err_total = 0;
        samples_checked = 0;
        do_reset();
        t_pwr();
        t_events();
        t_count();
        t_err();
        t_time();
        t_tone();
        t_init();
        results();
    end
endmodule : tb_speech_dsp_query_tone_commands
